// ==== design/asr_pkg.sv ====
// package: register map, field layouts, reset values, timing counts and carriers of the angle readout
package asr_pkg;

	// ---------------------------------------------------------------
	// clock and timing
	// ---------------------------------------------------------------
	localparam int CLK_MHZ = 125;
	localparam int REFRESH_NS = 1000;
	localparam int REFRESH_CYC = (REFRESH_NS * CLK_MHZ) / 1000;
	localparam int TIMEOUT_US = 25;
	localparam int TIMEOUT_CYC = TIMEOUT_US * CLK_MHZ;

	// ---------------------------------------------------------------
	// frame layout
	// ---------------------------------------------------------------
	localparam int ANGLE_W = 16;
	localparam int FRAME_W = ANGLE_W + 1;
	localparam logic [4:0] EDGE_PARITY = 5'h12;

	// ---------------------------------------------------------------
	// register offsets
	// ---------------------------------------------------------------
	localparam logic [4:0] REG_OFFSET_LOW = 5'h00;
	localparam logic [4:0] REG_OFFSET_HIGH = 5'h01;
	localparam logic [4:0] REG_BIAS_TRIM = 5'h02;
	localparam logic [4:0] REG_TRIM_AXIS = 5'h03;
	localparam logic [4:0] REG_INDEX_PULSE_LOW = 5'h04;
	localparam logic [4:0] REG_PULSE_HIGH = 5'h05;
	localparam logic [4:0] REG_FIELD_THRESH = 5'h06;
	localparam logic [4:0] REG_DIRECTION = 5'h09;
	localparam logic [4:0] REG_FIELD_STATUS = 5'h1b;

	// ---------------------------------------------------------------
	// reset values and writable-bit masks
	// ---------------------------------------------------------------
	localparam logic [7:0] RST_OFFSET_LOW = 8'h00;
	localparam logic [7:0] RST_OFFSET_HIGH = 8'h00;
	localparam logic [7:0] RST_BIAS_TRIM = 8'h00;
	localparam logic [7:0] RST_TRIM_AXIS = 8'h00;
	localparam logic [7:0] RST_INDEX_PULSE_LOW = 8'hc0;
	localparam logic [7:0] RST_PULSE_HIGH = 8'h3f;
	localparam logic [7:0] RST_FIELD_THRESH = 8'h1c;
	localparam logic [7:0] RST_DIRECTION = 8'h00;
	localparam logic [7:0] MASK_TRIM_AXIS = 8'h03;
	localparam logic [7:0] MASK_INDEX_PULSE_LOW = 8'hfc;
	localparam logic [7:0] MASK_PULSE_HIGH = 8'h3f;
	localparam logic [7:0] MASK_FIELD_THRESH = 8'hfc;
	localparam logic [7:0] MASK_DIRECTION = 8'h80;

	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int POS_X_TRIM = 0;
	localparam int POS_Y_TRIM = 1;
	localparam int POS_INDEX_LSB = 2;
	localparam int POS_PPT_LOW_LSB = 6;
	localparam int POS_PPT_HIGH_LSB = 0;
	localparam int POS_HIGH_THR_LSB = 2;
	localparam int POS_LOW_THR_LSB = 5;
	localparam int POS_DIRECTION = 7;
	localparam int POS_IN_RANGE_LSB = 3;
	localparam int POS_FIELD_LOW = 6;
	localparam int POS_FIELD_HIGH = 7;

	// ---------------------------------------------------------------
	// carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [15:0] zeroOffset;
		logic [7:0] biasTrimAmount;
		logic xAxisTrimEnable;
		logic yAxisTrimEnable;
		logic [7:0] encoderPulsesPerTurn;
		logic [3:0] indexShapeSetting;
		logic [2:0] fieldLowThreshold;
		logic [2:0] fieldHighThreshold;
		logic directionCcw;
	} asr_config_t;

	typedef struct packed {
		logic fieldHighFlag;
		logic fieldLowFlag;
		logic [2:0] fieldInRangeStatus;
	} asr_field_t;

	typedef struct packed {
		logic [4:0] addr;
		logic [7:0] data;
		logic wrEn;
		logic rdEn;
	} asr_reg_req_t;

	typedef enum logic {
		ASR_IDLE,
		ASR_FROZEN
	} asr_state_t;

endpackage : asr_pkg

// ==== design/asr_readout.sv ====
// angle ssi readout with sample fifo and configuration register map
`timescale 1ns/1ps
`default_nettype none

// -------------------------------------------------------------------
// sample fifo
// -------------------------------------------------------------------
module asr_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 4
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// fill side
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	// drain side
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	// pointers wrap naturally because the depth is a power of two;
	// the count is one bit wider so full and empty stay distinct
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	initial begin
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
			$error("asr_fifo: DEPTH must be a power of two of at least 2");
		end
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr_r;
	logic [AW-1:0] rdPtr_r;
	logic [AW:0] count_r;
	logic doPush;
	logic doPop;

	assign inReady = (count_r != (AW+1)'(DEPTH));
	assign outValid = (count_r != '0);
	assign doPush = inValid && inReady;
	assign doPop = outValid && outReady;
	assign outData = mem[rdPtr_r];

	always_ff @(posedge clk_sys) begin
		if (doPush) begin
			mem[wrPtr_r] <= inData;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
			count_r <= '0;
		end else begin
			if (doPush) begin
				wrPtr_r <= wrPtr_r + 1'b1;
			end
			if (doPop) begin
				rdPtr_r <= rdPtr_r + 1'b1;
			end
			if (doPush && !doPop) begin
				count_r <= count_r + 1'b1;
			end else if (doPop && !doPush) begin
				count_r <= count_r - 1'b1;
			end
		end
	end
endmodule : asr_fifo

// -------------------------------------------------------------------
// readout top
// -------------------------------------------------------------------
module asr_readout
	import asr_pkg::*;
#(
	parameter int FIFO_DEPTH = 4,
	parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// serial link pins
	input wire logic serialShiftClock,
	output logic serialData,
	// raw angle samples from the front end
	input wire logic rawValid,
	output logic rawReady,
	input wire logic [ANGLE_W-1:0] rawAngle,
	// field comparators
	input wire asr_field_t fieldIn,
	// register access port
	input wire asr_reg_req_t regReq,
	output logic [7:0] regRdData,
	// configuration towards analog front end and encoder
	output asr_config_t config_o,
	output logic frozen
);
	// the idle counter is 16 bits wide, so the timeout must fit in it
	initial begin
		if (TIMEOUT_CYCLES < 1 || TIMEOUT_CYCLES > 65535) begin
			$error("asr_readout: TIMEOUT_CYCLES out of range");
		end
	end

	// ---------------------------------------------------------------
	// register file
	// ---------------------------------------------------------------
	logic [7:0] offsetLow_r;
	logic [7:0] offsetHigh_r;
	logic [7:0] biasTrim_r;
	logic [7:0] trimAxis_r;
	logic [7:0] indexPulseLow_r;
	logic [7:0] pulseHigh_r;
	logic [7:0] fieldThresh_r;
	logic [7:0] direction_r;
	logic [7:0] fieldStatus;

	function automatic logic [7:0] regRead(input logic [4:0] addr, input logic [7:0] r0, input logic [7:0] r1,
			input logic [7:0] r2, input logic [7:0] r3, input logic [7:0] r4, input logic [7:0] r5,
			input logic [7:0] r6, input logic [7:0] r9, input logic [7:0] r27);
		logic [7:0] v;
		v = 8'h00;
		case (addr)
			REG_OFFSET_LOW: v = r0;
			REG_OFFSET_HIGH: v = r1;
			REG_BIAS_TRIM: v = r2;
			REG_TRIM_AXIS: v = r3;
			REG_INDEX_PULSE_LOW: v = r4;
			REG_PULSE_HIGH: v = r5;
			REG_FIELD_THRESH: v = r6;
			REG_DIRECTION: v = r9;
			REG_FIELD_STATUS: v = r27;
			default: v = 8'h00;
		endcase
		return v;
	endfunction : regRead

	// write decode for one register address
	function automatic logic hit(input asr_reg_req_t q, input logic [4:0] addr);
		return q.wrEn && (q.addr == addr);
	endfunction : hit

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			offsetLow_r <= RST_OFFSET_LOW;
			offsetHigh_r <= RST_OFFSET_HIGH;
			biasTrim_r <= RST_BIAS_TRIM;
			trimAxis_r <= RST_TRIM_AXIS;
			indexPulseLow_r <= RST_INDEX_PULSE_LOW;
			pulseHigh_r <= RST_PULSE_HIGH;
			fieldThresh_r <= RST_FIELD_THRESH;
			direction_r <= RST_DIRECTION;
		end else begin
			if (hit(regReq, REG_OFFSET_LOW)) offsetLow_r <= regReq.data;
			if (hit(regReq, REG_OFFSET_HIGH)) offsetHigh_r <= regReq.data;
			if (hit(regReq, REG_BIAS_TRIM)) biasTrim_r <= regReq.data;
			if (hit(regReq, REG_TRIM_AXIS)) trimAxis_r <= regReq.data & MASK_TRIM_AXIS;
			if (hit(regReq, REG_INDEX_PULSE_LOW)) indexPulseLow_r <= regReq.data & MASK_INDEX_PULSE_LOW;
			if (hit(regReq, REG_PULSE_HIGH)) pulseHigh_r <= regReq.data & MASK_PULSE_HIGH;
			if (hit(regReq, REG_FIELD_THRESH)) fieldThresh_r <= regReq.data & MASK_FIELD_THRESH;
			if (hit(regReq, REG_DIRECTION)) direction_r <= regReq.data & MASK_DIRECTION;
		end
	end

	// status is read-only; writes to it fall through as unmapped
	always_comb begin
		fieldStatus = 8'h00;
		fieldStatus[POS_FIELD_HIGH] = fieldIn.fieldHighFlag;
		fieldStatus[POS_FIELD_LOW] = fieldIn.fieldLowFlag;
		fieldStatus[POS_IN_RANGE_LSB +: 3] = fieldIn.fieldInRangeStatus;
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			regRdData <= 8'h00;
		end else if (regReq.rdEn) begin
			regRdData <= regRead(regReq.addr, offsetLow_r, offsetHigh_r, biasTrim_r, trimAxis_r,
				indexPulseLow_r, pulseHigh_r, fieldThresh_r, direction_r, fieldStatus);
		end
	end

	// configuration fields unpacked for the front end and the encoder;
	// read-only bits were masked on write, so they never reach here
	always_comb begin
		config_o.zeroOffset = {offsetHigh_r, offsetLow_r};
		config_o.biasTrimAmount = biasTrim_r;
		config_o.xAxisTrimEnable = trimAxis_r[POS_X_TRIM];
		config_o.yAxisTrimEnable = trimAxis_r[POS_Y_TRIM];
		config_o.encoderPulsesPerTurn = {pulseHigh_r[POS_PPT_HIGH_LSB +: 6],
			indexPulseLow_r[POS_PPT_LOW_LSB +: 2]};
		config_o.indexShapeSetting = indexPulseLow_r[POS_INDEX_LSB +: 4];
		config_o.fieldLowThreshold = fieldThresh_r[POS_LOW_THR_LSB +: 3];
		config_o.fieldHighThreshold = fieldThresh_r[POS_HIGH_THR_LSB +: 3];
		config_o.directionCcw = direction_r[POS_DIRECTION];
	end

	// ---------------------------------------------------------------
	// sample path: fifo stalls the front end while frozen
	// ---------------------------------------------------------------
	logic sampleValid;
	logic sampleReady;
	logic [ANGLE_W-1:0] sampleData;
	logic [6:0] refreshCnt_r;
	logic refreshTick;
	asr_state_t state_r;

	asr_fifo #(
		.WIDTH(ANGLE_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.inValid(rawValid),
		.inReady(rawReady),
		.inData(rawAngle),
		.outValid(sampleValid),
		.outReady(sampleReady),
		.outData(sampleData)
	);

	// refresh tick is free running; a tick that falls inside a frame is lost
	// and the sample waits in the fifo for the first tick after release
	assign refreshTick = (refreshCnt_r == 7'(REFRESH_CYC - 1));
	assign sampleReady = refreshTick && (state_r == ASR_IDLE);

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			refreshCnt_r <= 7'h00;
		end else if (refreshTick) begin
			refreshCnt_r <= 7'h00;
		end else begin
			refreshCnt_r <= refreshCnt_r + 7'h01;
		end
	end

	// direction then zero offset; the sum wraps in 16 bits
	logic [ANGLE_W-1:0] dirAngle;
	logic [ANGLE_W-1:0] zeroPos;
	logic [ANGLE_W-1:0] outAngle;
	logic [ANGLE_W-1:0] buffer_r;

	assign dirAngle = config_o.directionCcw ? ANGLE_W'(-sampleData) : sampleData;
	assign zeroPos = ANGLE_W'(17'h10000 - {1'b0, config_o.zeroOffset});
	assign outAngle = ANGLE_W'(dirAngle - zeroPos);

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			buffer_r <= '0;
		end else if (sampleValid && sampleReady) begin
			buffer_r <= outAngle;
		end
	end

	// ---------------------------------------------------------------
	// serial link
	// ---------------------------------------------------------------
	logic sckMeta_r;
	logic sckSync_r;
	logic sckPrev_r;
	logic sckRise;
	logic sckFall;
	logic [4:0] edgeCnt_r;
	logic [FRAME_W-1:0] shift_r;
	logic [15:0] idleCnt_r;

	// two-stage synchroniser plus edge detector; all stages reset to the idle
	// high level so no false edge follows reset
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			sckMeta_r <= 1'b1;
			sckSync_r <= 1'b1;
			sckPrev_r <= 1'b1;
		end else begin
			sckMeta_r <= serialShiftClock;
			sckSync_r <= sckMeta_r;
			sckPrev_r <= sckSync_r;
		end
	end

	assign sckRise = sckSync_r && !sckPrev_r;
	assign sckFall = !sckSync_r && sckPrev_r;

	// frame control: the first rise freezes the buffer, every edge restarts
	// the idle count, and the timeout after the last edge releases it;
	// the edge count saturates so an overlong frame cannot wrap into data
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			state_r <= ASR_IDLE;
			edgeCnt_r <= 5'h00;
			idleCnt_r <= 16'h0000;
		end else begin
			case (state_r)
				ASR_IDLE: begin
					if (sckRise) begin
						state_r <= ASR_FROZEN;
						edgeCnt_r <= 5'h01;
						idleCnt_r <= 16'h0000;
					end
				end
				ASR_FROZEN: begin
					if (sckRise || sckFall) begin
						idleCnt_r <= 16'h0000;
						if (sckRise && edgeCnt_r != 5'h1f) begin
							edgeCnt_r <= edgeCnt_r + 5'h01;
						end
					end else if (idleCnt_r == 16'(TIMEOUT_CYCLES - 1)) begin
						state_r <= ASR_IDLE;
						edgeCnt_r <= 5'h00;
					end else begin
						idleCnt_r <= idleCnt_r + 16'h0001;
					end
				end
				default: begin
					state_r <= ASR_IDLE;
				end
			endcase
		end
	end

	// frame is only ever the angle buffer; no register data reaches this link
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			shift_r <= '0;
			serialData <= 1'b1;
		end else if (state_r == ASR_IDLE) begin
			serialData <= 1'b1;
			if (sckRise) begin
				shift_r <= {buffer_r, ^buffer_r};
			end
		end else if (sckRise) begin
			// rises two to seventeen carry the word, rise eighteen the check bit,
			// and anything later shifts out zeros
			if (edgeCnt_r >= 5'h01 && edgeCnt_r < EDGE_PARITY) begin
				serialData <= shift_r[FRAME_W-1];
				shift_r <= {shift_r[FRAME_W-2:0], 1'b0};
			end else begin
				serialData <= 1'b0;
			end
		end
	end

	// frozen is a plain decode of the state register
	assign frozen = (state_r == ASR_FROZEN);
endmodule : asr_readout

`default_nettype wire

// ==== sim/asr_readout_props.sv ====
// assertion checker for the angle readout ports
`timescale 1ns/1ps
`default_nettype none
module asr_readout_props
	import asr_pkg::*;
#(
	parameter int TIMEOUT_CYCLES = 50
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// link and sample side
	input wire logic serialShiftClock,
	input wire logic serialData,
	input wire logic rawReady,
	input wire logic frozen,
	// registers
	input wire asr_field_t fieldIn,
	input wire asr_reg_req_t regReq,
	input wire logic [7:0] regRdData,
	input wire asr_config_t config_o
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	// -----------------------------------------------------------
	// cycles since the last rising pin edge, saturating
	// -----------------------------------------------------------
	logic [15:0] riseAge_r;
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			riseAge_r <= 16'hffff;
		else if ($rose(serialShiftClock))
			riseAge_r <= 16'h0000;
		else if (riseAge_r != 16'hffff)
			riseAge_r <= riseAge_r + 16'h0001;
	end
	// -----------------------------------------------------------
	// assertions
	// -----------------------------------------------------------
	a_freeze_start: assert property ($rose(serialShiftClock) |-> ##[1:4] frozen)
		else $error("buffer not frozen after link rising edge");
	a_dummy_idle: assert property ($rose(frozen) |-> serialData)
		else $error("data moved on start clock");
	a_hold_frozen: assert property ($fell(frozen) |-> riseAge_r >= TIMEOUT_CYCLES - 8)
		else $error("buffer released before timeout");
	a_release_bound: assert property (riseAge_r == TIMEOUT_CYCLES + 8 |-> !frozen)
		else $error("buffer still frozen after timeout");
	a_status_read: assert property (regReq.rdEn && regReq.addr == REG_FIELD_STATUS |=>
		regRdData == {$past(fieldIn), 3'h0})
		else $error("field status read wrong");
	a_offset_map: assert property (regReq.wrEn && regReq.addr == REG_OFFSET_LOW |=>
		config_o.zeroOffset[7:0] == $past(regReq.data))
		else $error("zero offset low byte not applied");
	a_dir_map: assert property (regReq.wrEn && regReq.addr == REG_DIRECTION |=>
		config_o.directionCcw == $past(regReq.data[7]))
		else $error("direction bit not applied");
	a_ppt_map: assert property (regReq.wrEn && regReq.addr == REG_PULSE_HIGH |=>
		config_o.encoderPulsesPerTurn[7:2] == 6'($past(regReq.data)))
		else $error("pulse count high bits not applied");
	a_thresh_map: assert property (regReq.wrEn && regReq.addr == REG_FIELD_THRESH |=>
		{config_o.fieldLowThreshold, config_o.fieldHighThreshold} == 6'($past(regReq.data) >> 2))
		else $error("field thresholds not applied");
	c_release: cover property ($fell(frozen));
	c_full: cover property (!rawReady);
	c_status: cover property (regReq.rdEn && regReq.addr == REG_FIELD_STATUS);
endmodule : asr_readout_props
bind asr_readout asr_readout_props #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) props_u (.clk_sys(clk_sys), .arst_n(arst_n),
	.serialShiftClock(serialShiftClock), .serialData(serialData), .rawReady(rawReady), .frozen(frozen),
	.fieldIn(fieldIn), .regReq(regReq), .regRdData(regRdData), .config_o(config_o));
`default_nettype wire

// ==== sim/asr_readout_tb.sv ====
// self-checking bench for the angle readout
`timescale 1ns/1ps
`default_nettype none
module asr_readout_tb
	import asr_pkg::*;
;
	localparam int TMO = 50;
	logic clk_sys = 1'b0;
	logic arst_n = 1'b0;
	logic rawValid = 1'b0;
	logic [15:0] rawAngle = 16'h0000;
	asr_field_t fieldIn = '0;
	asr_reg_req_t regReq = '0;
	wire serialData, rawReady, frozen, sck, frameDone;
	wire [7:0] regRdData;
	wire [16:0] frameWord;
	asr_config_t cfg;
	int err_total = 0;
	int samples_checked = 0;
	int cycles = 0;
	logic rdPend = 1'b0;
	logic [16:0] expAngle [$];
	logic [7:0] expReg [$];
	logic [15:0] z = 16'h0000;
	logic dir = 1'b0;
	logic [16:0] lastExp;
	logic [15:0] v;
	logic [7:0] d;
	logic [4:0] addrs [8] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h09};
	logic [7:0] rstv [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hc0, 8'h3f, 8'h1c, 8'h00};
	logic [7:0] mask [8] = '{8'hff, 8'hff, 8'hff, 8'h03, 8'hfc, 8'h3f, 8'hfc, 8'h80};

	always #4 clk_sys = ~clk_sys;

	asr_readout #(.FIFO_DEPTH(4), .TIMEOUT_CYCLES(TMO)) dut_u (.clk_sys(clk_sys), .arst_n(arst_n),
		.serialShiftClock(sck), .serialData(serialData), .rawValid(rawValid), .rawReady(rawReady),
		.rawAngle(rawAngle), .fieldIn(fieldIn), .regReq(regReq), .regRdData(regRdData), .config_o(cfg),
		.frozen(frozen));
	asr_ssi_master ssi_u (.sck(sck), .sdata(serialData), .frameDone(frameDone), .frameWord(frameWord));

	// -----------------------------------------------------------
	// compare and report
	// -----------------------------------------------------------
	task automatic chkAngle(input logic [16:0] got, input logic [16:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chkAngle
	task automatic chkReg(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chkReg
	task automatic results();
		$display("checks=%0d mismatches=%0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : results

	always @(posedge frameDone) chkAngle(frameWord, expAngle.pop_front());
	always @(posedge clk_sys) begin
		if (rdPend)
			chkReg(regRdData, expReg.pop_front());
		rdPend <= regReq.rdEn;
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			results();
		end
	end

	// -----------------------------------------------------------
	// drivers
	// -----------------------------------------------------------
	task automatic regWr(input logic [4:0] a, input logic [7:0] dv);
		@(posedge clk_sys);
		regReq <= {a, dv, 1'b1, 1'b0};
		@(posedge clk_sys);
		regReq <= '0;
	endtask : regWr
	task automatic regRd(input logic [4:0] a, input logic [7:0] e);
		expReg.push_back(e);
		@(posedge clk_sys);
		regReq <= {a, 8'h00, 1'b0, 1'b1};
		@(posedge clk_sys);
		regReq <= '0;
	endtask : regRd
	task automatic pushRaw(input logic [15:0] s);
		@(posedge clk_sys);
		rawValid <= 1'b1;
		rawAngle <= s;
		do @(posedge clk_sys); while (rawReady !== 1'b1);
		rawValid <= 1'b0;
	endtask : pushRaw
	function automatic logic [16:0] expOf(input logic [15:0] raw);
		logic [15:0] a;
		a = (dir ? 16'h0000 - raw : raw) + z;
		return {a, ^a};
	endfunction : expOf
	task automatic frame(input int n, input logic [16:0] e);
		expAngle.push_back(e >> (18 - n));
		ssi_u.read(n);
		// dead time scaled with the shortened timeout
		repeat (TMO + 100) @(posedge clk_sys);
	endtask : frame

	// -----------------------------------------------------------
	// tests
	// -----------------------------------------------------------
	initial begin
		void'($urandom(43));
		repeat (3) @(posedge clk_sys);
		arst_n <= 1'b1;
		fieldIn <= 5'($urandom);
		for (int i = 0; i < 8; i++) regRd(addrs[i], rstv[i]);
		regRd(REG_FIELD_STATUS, {fieldIn, 3'h0});
		regRd(5'h07, 8'h00);
		$display("test reset values done");
		for (int i = 0; i < 8; i++) begin
			d = 8'($urandom);
			regWr(addrs[i], d);
			regRd(addrs[i], d & mask[i]);
		end
		regWr(REG_FIELD_STATUS, 8'h00);
		regRd(REG_FIELD_STATUS, {fieldIn, 3'h0});
		regWr(5'h07, 8'hff);
		regRd(5'h07, 8'h00);
		$display("test register map done");
		for (int i = 0; i < 4; i++) begin
			z = (i == 0) ? 16'h0000 : 16'($urandom);
			dir = i[0];
			regWr(REG_OFFSET_LOW, z[7:0]);
			regWr(REG_OFFSET_HIGH, z[15:8]);
			regWr(REG_DIRECTION, {dir, 7'h00});
			v = 16'($urandom);
			pushRaw(v);
			repeat (260) @(posedge clk_sys);
			lastExp = expOf(v);
			frame((i == 3) ? 13 : 18, lastExp);
		end
		$display("test angle frames done");
		expAngle.push_back(lastExp);
		fork
			ssi_u.read(18);
			begin
				repeat (20) @(posedge clk_sys);
				for (int i = 0; i < 4; i++) begin
					v = 16'($urandom);
					pushRaw(v);
				end
				@(posedge clk_sys);
				chkReg({7'h00, rawReady}, 8'h00);
			end
		join
		repeat (TMO + 700) @(posedge clk_sys);
		chkReg({7'h00, rawReady}, 8'h01);
		frame(18, expOf(v));
		$display("test freeze and fifo done");
		results();
	end
endmodule : asr_readout_tb
`default_nettype wire

// ==== sim/asr_ssi_master.sv ====
// ssi master model reading angle frames
`timescale 1ns/1ps
`default_nettype none
module asr_ssi_master (
	// link pins
	output logic sck,
	input wire logic sdata,
	// frame result
	output logic frameDone,
	output logic [16:0] frameWord
);
	initial begin
		sck = 1'b1;
		frameDone = 1'b0;
		frameWord = 17'h00000;
	end
	// n rising edges: start clock, then bits right-aligned; clock rests high after
	task automatic read(input int n);
		logic [16:0] w;
		w = 17'h00000;
		#3;
		for (int k = 1; k <= n; k++) begin
			sck = 1'b0;
			#40;
			sck = 1'b1;
			#40;
			if (k > 1)
				w = {w[15:0], sdata};
		end
		frameWord = w;
		frameDone = 1'b1;
		#1;
		frameDone = 1'b0;
	endtask : read
endmodule : asr_ssi_master
`default_nettype wire
